//--- verilog/sem_defines.svh
// register offsets, reset values and timing counts of the supply enable block
`ifndef SEM_DEFINES_SVH
`define SEM_DEFINES_SVH

`define SEM_ADDR_W 12
`define SEM_NUM_PSEN 12
`define SEM_NUM_PWM 8
`define SEM_NUM_FLT 3

`define SEM_PSEN_POL_OFS 12'h000
`define SEM_PSEN_OD_OFS 12'h004
`define SEM_PSEN_GPO_OFS 12'h008
`define SEM_PSEN_DRIVE_OFS 12'h00c
`define SEM_PWM_EN_OFS 12'h010
`define SEM_PWM_GPO_OFS 12'h014
`define SEM_PWM_GVAL_OFS 12'h018
`define SEM_PWM_DUTY0_OFS 12'h01c
`define SEM_PWM_DUTY7_OFS 12'h038
`define SEM_FLT_ASSERT0_OFS 12'h03c
`define SEM_FLT_SHDN0_OFS 12'h048
`define SEM_IRQ_STATUS_OFS 12'h054
`define SEM_IRQ_MASK_OFS 12'h058
`define SEM_PIN_STATE_OFS 12'h05c

`define SEM_PSEN_POL_RST 12'hfff
`define SEM_DUTY_FULL 8'hff
`define SEM_PWM_CNT_MAX 8'hfe

`define SEM_CLK_MHZ 200
`define SEM_PWM_STEP_NS 100
`define SEM_PWM_DIV ((`SEM_PWM_STEP_NS * `SEM_CLK_MHZ) / 1000)

`endif

//--- verilog/sem_pkg.sv
// types of the supply enable, margin and fault line block
`include "sem_defines.svh"

package sem_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`SEM_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} sem_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} sem_apb_rsp_t;

	typedef struct packed {
		logic [`SEM_NUM_PSEN-1:0] val;
		logic [`SEM_NUM_PSEN-1:0] oe_n;
	} sem_psen_pins_t;

	typedef struct packed {
		logic [`SEM_NUM_PWM-1:0] val;
		logic [`SEM_NUM_PWM-1:0] oe_n;
	} sem_pwm_pins_t;

	typedef struct packed {
		logic [`SEM_NUM_FLT-1:0] val;
		logic [`SEM_NUM_FLT-1:0] oe_n;
	} sem_flt_pins_t;

	typedef struct packed {
		logic [`SEM_NUM_PSEN-1:0] psen_pol;
		logic [`SEM_NUM_PSEN-1:0] psen_od;
		logic [`SEM_NUM_PSEN-1:0] psen_gpo;
		logic [`SEM_NUM_PSEN-1:0] psen_drive;
		logic [`SEM_NUM_PWM-1:0] pwm_en;
		logic [`SEM_NUM_PWM-1:0] pwm_gpo;
		logic [`SEM_NUM_PWM-1:0] pwm_gval;
		logic [`SEM_NUM_PWM-1:0][7:0] pwm_duty;
		logic [`SEM_NUM_FLT-1:0][`SEM_NUM_PSEN-1:0] flt_assert;
		logic [`SEM_NUM_FLT-1:0][`SEM_NUM_PSEN-1:0] flt_shdn;
		logic [3:0] irq_status;
		logic [3:0] irq_mask;
		logic [`SEM_NUM_FLT-1:0] flt_sync1;
		logic [`SEM_NUM_FLT-1:0] flt_sync2;
		logic [`SEM_NUM_FLT-1:0] flt_prev;
		logic shdn_prev;
		logic active;
		logic [1:0] mon_hist;
		logic [7:0] pre_cnt;
		logic [7:0] pwm_cnt;
		logic [31:0] prdata;
		logic pslverr;
	} sem_state_t;

endpackage : sem_pkg

//--- verilog/sem_supply_pins.sv
// supply enable, margin pulse and shared fault line pin logic with apb registers
//
// Added by the designer: the APB interface to the registers and the address map.
`include "sem_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sem_supply_pins (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rstn_in,
	// apb slave
	input wire sem_pkg::sem_apb_req_t apb_req_in,
	output sem_pkg::sem_apb_rsp_t apb_rsp_out,
	// status from the monitoring engine, same clock
	input wire logic recall_done_in,
	input wire logic monitor_active_in,
	input wire logic [`SEM_NUM_PSEN-1:0] chan_fault_in,
	// pins
	output sem_pkg::sem_psen_pins_t psen_pins_out,
	output sem_pkg::sem_pwm_pins_t pwm_pins_out,
	output sem_pkg::sem_flt_pins_t flt_pins_out,
	input wire logic [`SEM_NUM_FLT-1:0] flt_pins_in,
	// channel shutdown and interrupt
	output logic [`SEM_NUM_PSEN-1:0] chan_shutdown_out,
	output logic irq_out
);
	import sem_pkg::*;

	sem_state_t r;
	sem_state_t nxt;
	logic [`SEM_NUM_FLT-1:0] line_fault;
	logic [`SEM_NUM_PSEN-1:0] shdn;
	logic [`SEM_NUM_PSEN-1:0] psen_logic;
	logic [`SEM_NUM_PSEN-1:0] psen_level;
	logic setup;
	logic access_wr;
	logic tick;
	logic [3:0] irq_set;
	logic [`SEM_ADDR_W-1:0] duty_rel;

	assign setup = apb_req_in.psel && !apb_req_in.penable;
	assign access_wr = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
	assign tick = (r.pre_cnt == 8'(`SEM_PWM_DIV - 1));
	assign duty_rel = apb_req_in.paddr - `SEM_PWM_DUTY0_OFS;

	always_comb begin
		for (int n = 0; n < `SEM_NUM_FLT; n++) begin
			// per line fault map
			// line fault map
			line_fault[n] = |(chan_fault_in & r.flt_assert[n]);
		end
		shdn = '0;
		for (int n = 0; n < `SEM_NUM_FLT; n++) begin
			// shutdown on line
			// our own pull still shows in the synchroniser for two cycles after start
			if (monitor_active_in && r.mon_hist[1] && !r.flt_sync2[n]) begin
				shdn = shdn | r.flt_shdn[n];
			end
		end
	end

	assign chan_shutdown_out = shdn;

	always_comb begin
		nxt = r;
		irq_set = '0;
		nxt.active = r.active | recall_done_in;
		nxt.flt_sync1 = flt_pins_in;
		nxt.flt_sync2 = r.flt_sync1;
		nxt.flt_prev = r.flt_sync2;
		nxt.shdn_prev = |shdn;
		nxt.mon_hist = {r.mon_hist[0], monitor_active_in};
		if (monitor_active_in) begin
			irq_set[2:0] = r.flt_prev & ~r.flt_sync2;
		end
		irq_set[3] = (|shdn) && !r.shdn_prev;
		nxt.pre_cnt = tick ? 8'h00 : r.pre_cnt + 8'h01;
		if (tick) begin
			nxt.pwm_cnt = (r.pwm_cnt == `SEM_PWM_CNT_MAX) ? 8'h00 : r.pwm_cnt + 8'h01;
		end
		if (setup) begin
			nxt.pslverr = 1'b0;
			unique case (apb_req_in.paddr)
				`SEM_PSEN_POL_OFS: nxt.prdata = {20'h00000, r.psen_pol};
				`SEM_PSEN_OD_OFS: nxt.prdata = {20'h00000, r.psen_od};
				`SEM_PSEN_GPO_OFS: nxt.prdata = {20'h00000, r.psen_gpo};
				`SEM_PSEN_DRIVE_OFS: nxt.prdata = {20'h00000, r.psen_drive};
				`SEM_PWM_EN_OFS: nxt.prdata = {24'h000000, r.pwm_en};
				`SEM_PWM_GPO_OFS: nxt.prdata = {24'h000000, r.pwm_gpo};
				`SEM_PWM_GVAL_OFS: nxt.prdata = {24'h000000, r.pwm_gval};
				`SEM_IRQ_STATUS_OFS: nxt.prdata = {28'h0000000, r.irq_status};
				`SEM_IRQ_MASK_OFS: nxt.prdata = {28'h0000000, r.irq_mask};
				`SEM_PIN_STATE_OFS: nxt.prdata = {15'h0000, shdn, r.flt_sync2,
					monitor_active_in, r.active};
				default: begin
					nxt.prdata = 32'h00000000;
					nxt.pslverr = 1'b1;
					if (apb_req_in.paddr >= `SEM_PWM_DUTY0_OFS &&
						apb_req_in.paddr <= `SEM_PWM_DUTY7_OFS &&
						apb_req_in.paddr[1:0] == 2'h0) begin
						nxt.prdata = {24'h000000, r.pwm_duty[duty_rel[4:2]]};
						nxt.pslverr = 1'b0;
					end
					for (int n = 0; n < `SEM_NUM_FLT; n++) begin
						if (apb_req_in.paddr == `SEM_FLT_ASSERT0_OFS + `SEM_ADDR_W'(4 * n)) begin
							nxt.prdata = {20'h00000, r.flt_assert[n]};
							nxt.pslverr = 1'b0;
						end
						if (apb_req_in.paddr == `SEM_FLT_SHDN0_OFS + `SEM_ADDR_W'(4 * n)) begin
							nxt.prdata = {20'h00000, r.flt_shdn[n]};
							nxt.pslverr = 1'b0;
						end
					end
				end
			endcase
		end
		nxt.irq_status = r.irq_status | irq_set;
		if (access_wr && !r.pslverr) begin
			unique case (apb_req_in.paddr)
				`SEM_PSEN_POL_OFS: nxt.psen_pol = apb_req_in.pwdata[11:0];
				`SEM_PSEN_OD_OFS: nxt.psen_od = apb_req_in.pwdata[11:0];
				`SEM_PSEN_GPO_OFS: nxt.psen_gpo = apb_req_in.pwdata[11:0];
				`SEM_PSEN_DRIVE_OFS: nxt.psen_drive = apb_req_in.pwdata[11:0];
				`SEM_PWM_EN_OFS: nxt.pwm_en = apb_req_in.pwdata[7:0];
				`SEM_PWM_GPO_OFS: nxt.pwm_gpo = apb_req_in.pwdata[7:0];
				`SEM_PWM_GVAL_OFS: nxt.pwm_gval = apb_req_in.pwdata[7:0];
				// set wins over the write-one clear
				`SEM_IRQ_STATUS_OFS: nxt.irq_status = (r.irq_status & ~apb_req_in.pwdata[3:0])
					| irq_set;
				`SEM_IRQ_MASK_OFS: nxt.irq_mask = apb_req_in.pwdata[3:0];
				default: begin
					if (apb_req_in.paddr >= `SEM_PWM_DUTY0_OFS &&
						apb_req_in.paddr <= `SEM_PWM_DUTY7_OFS) begin
						nxt.pwm_duty[duty_rel[4:2]] = apb_req_in.pwdata[7:0];
					end
					for (int n = 0; n < `SEM_NUM_FLT; n++) begin
						if (apb_req_in.paddr == `SEM_FLT_ASSERT0_OFS + `SEM_ADDR_W'(4 * n)) begin
							nxt.flt_assert[n] = apb_req_in.pwdata[11:0];
						end
						if (apb_req_in.paddr == `SEM_FLT_SHDN0_OFS + `SEM_ADDR_W'(4 * n)) begin
							nxt.flt_shdn[n] = apb_req_in.pwdata[11:0];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r <= '0;
			r.psen_pol <= `SEM_PSEN_POL_RST;
			r.flt_sync1 <= '1;
			r.flt_sync2 <= '1;
			r.flt_prev <= '1;
		end else begin
			r <= nxt;
		end
	end

	assign apb_rsp_out = '{pready: apb_req_in.psel && apb_req_in.penable,
		prdata: r.prdata,
		pslverr: apb_req_in.psel && apb_req_in.penable && r.pslverr};
	assign irq_out = |(r.irq_status & r.irq_mask);

	assign psen_logic = (r.psen_gpo & r.psen_drive) | (~r.psen_gpo & r.psen_drive & ~shdn);
	assign psen_level = ~(psen_logic ^ r.psen_pol);

	always_comb begin
		for (int i = 0; i < `SEM_NUM_PSEN; i++) begin
			if (!r.active) begin
				psen_pins_out.val[i] = 1'b0;
				psen_pins_out.oe_n[i] = 1'b1;
			end else if (r.psen_od[i]) begin
				psen_pins_out.val[i] = 1'b0;
				psen_pins_out.oe_n[i] = psen_level[i];
			end else begin
				psen_pins_out.val[i] = psen_level[i];
				psen_pins_out.oe_n[i] = 1'b0;
			end
		end
		for (int i = 0; i < `SEM_NUM_PWM; i++) begin
			pwm_pins_out.val[i] = 1'b0;
			pwm_pins_out.oe_n[i] = 1'b1;
			if (r.active && r.pwm_gpo[i]) begin
				pwm_pins_out.val[i] = r.pwm_gval[i];
				pwm_pins_out.oe_n[i] = 1'b0;
			end else if (r.active && r.pwm_en[i]) begin
				pwm_pins_out.val[i] = (r.pwm_cnt < r.pwm_duty[i]);
				pwm_pins_out.oe_n[i] = 1'b0;
			end
		end
		for (int n = 0; n < `SEM_NUM_FLT; n++) begin
			flt_pins_out.val[n] = 1'b0;
			flt_pins_out.oe_n[n] = !(r.active && (!monitor_active_in || line_fault[n]));
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	pins_float_a: assert property (
		!r.active |->
		(&psen_pins_out.oe_n) && (&pwm_pins_out.oe_n))
		else $error("pin driven before recall");

	flt_released_a: assert property (
		!r.active |->
		&flt_pins_out.oe_n)
		else $error("fault line pulled before recall");

	flt_hold_a: assert property (
		$rose(r.active) && !monitor_active_in |->
		flt_pins_out.oe_n == 3'h0)
		else $error("fault lines not pulled low after recall");

	flt_held_a: assert property (
		r.active && !monitor_active_in |->
		flt_pins_out.oe_n == 3'h0)
		else $error("fault line released before monitoring");

	flt_release_a: assert property (
		r.active && monitor_active_in && chan_fault_in == 12'h000 |->
		&flt_pins_out.oe_n)
		else $error("fault line held with no fault");

	flt_map_a: assert property (
		r.active && monitor_active_in && chan_fault_in == 12'h004 &&
		r.flt_assert[1][2] && !r.flt_assert[0][2] && !r.flt_assert[2][2] |->
		!flt_pins_out.oe_n[1] && flt_pins_out.oe_n[0] && flt_pins_out.oe_n[2])
		else $error("fault map not honoured");

	flt_pull_a: assert property (
		r.active && monitor_active_in && (chan_fault_in & r.flt_assert[1]) != 12'h000 |->
		!flt_pins_out.oe_n[1])
		else $error("mapped fault did not pull its line");

	flt_od_a: assert property (
		1'b1 |->
		flt_pins_out.val == 3'h0)
		else $error("fault line driven high");

	chan_shdn_a: assert property (
		(monitor_active_in && !flt_pins_in[0] && r.flt_shdn[0][7])[*3] |->
		chan_shutdown_out[7])
		else $error("channel not shut down by fault line");

	shdn_idle_a: assert property (
		!monitor_active_in |->
		chan_shutdown_out == 12'h000)
		else $error("shutdown while not monitoring");

	shdn_start_a: assert property (
		$rose(monitor_active_in) |->
		chan_shutdown_out == 12'h000)
		else $error("shutdown from own pull at monitoring start");

	psen_pol_a: assert property (
		r.active && !r.psen_od[0] && !r.psen_gpo[0] && !shdn[0] |->
		psen_pins_out.val[0] == (r.psen_drive[0] ~^ r.psen_pol[0]))
		else $error("supply enable polarity wrong");

	psen_od_a: assert property (
		r.active && r.psen_od[0] && !r.psen_gpo[0] && !shdn[0] |->
		!psen_pins_out.val[0] && psen_pins_out.oe_n[0] == (r.psen_drive[0] ~^ r.psen_pol[0]))
		else $error("open drain supply enable wrong");

	psen_gpo_a: assert property (
		r.active && r.psen_gpo[5] && !r.psen_od[5] && r.psen_pol[5] |->
		psen_pins_out.val[5] == r.psen_drive[5] && !psen_pins_out.oe_n[5])
		else $error("general output level wrong");

	pwm_hiz_a: assert property (
		1'b1 |->
		((~r.pwm_en & ~r.pwm_gpo) & ~pwm_pins_out.oe_n) == 8'h00)
		else $error("margin output driven while off");

	pwm_full_a: assert property (
		(r.active && r.pwm_en[0] && !r.pwm_gpo[0] &&
		r.pwm_duty[0] == `SEM_DUTY_FULL)[*4] |->
		pwm_pins_out.val[0] && !pwm_pins_out.oe_n[0])
		else $error("full duty output went low");

	pwm_zero_a: assert property (
		(r.active && r.pwm_en[1] && !r.pwm_gpo[1] &&
		r.pwm_duty[1] == 8'h00)[*4] |->
		!pwm_pins_out.val[1] && !pwm_pins_out.oe_n[1])
		else $error("zero duty output went high");

	pwm_gpo_a: assert property (
		r.active && r.pwm_gpo[7] |->
		!pwm_pins_out.oe_n[7] && pwm_pins_out.val[7] == r.pwm_gval[7])
		else $error("margin general output wrong");

endmodule : sem_supply_pins
`default_nettype wire

//--- test/sem_peer_model.sv
// peer manager and pull-ups that share the three fault lines with the block
`timescale 1ns/1ps
`default_nettype none

module sem_peer_model (
	// block side, low enable pulls the line
	input wire logic [2:0] flt_oe_n_in,
	// peer device pull requests
	input wire logic [2:0] peer_pull_in,
	// wired level sensed by every device
	output logic [2:0] flt_line_out
);
	assign flt_line_out = flt_oe_n_in & ~peer_pull_in;
endmodule : sem_peer_model

`default_nettype wire

//--- test/sem_supply_pins_bench.sv
// self-checking bench of the supply enable, margin and fault line pins
`include "sem_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sem_supply_pins_bench;
	import sem_pkg::*;
	logic core_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	sem_apb_req_t req = '0;
	sem_apb_rsp_t rsp;
	logic recall = 1'b0;
	logic mon = 1'b0;
	logic [11:0] cfault = 12'h000;
	logic [2:0] peer = 3'h0;
	sem_psen_pins_t psen;
	sem_pwm_pins_t pwm;
	sem_flt_pins_t flt;
	logic [2:0] line;
	logic [11:0] shdn;
	logic irq;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;

	always #2.5 core_clk_in = ~core_clk_in;

	sem_supply_pins i_sem_supply_pins (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.apb_req_in(req), .apb_rsp_out(rsp), .recall_done_in(recall),
		.monitor_active_in(mon), .chan_fault_in(cfault), .psen_pins_out(psen),
		.pwm_pins_out(pwm), .flt_pins_out(flt), .flt_pins_in(line),
		.chan_shutdown_out(shdn), .irq_out(irq));
	sem_peer_model i_sem_peer_model (.flt_oe_n_in(flt.oe_n), .peer_pull_in(peer),
		.flt_line_out(line));

	task automatic results();
		if (fails == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge core_clk_in);
		req.penable <= 1'b1;
		@(posedge core_clk_in);
		while (rsp.pready !== 1'b1) begin
			@(posedge core_clk_in);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic settle();
		@(posedge core_clk_in);
		#1;
	endtask : settle

	task automatic t_float();
		repeat (10) settle();
		chk(flt.oe_n, 3'h7);
		chk({psen.oe_n, pwm.oe_n}, 20'hfffff);
		@(posedge core_clk_in);
		rstn_in <= 1'b1;
		apb(1'b0, `SEM_PSEN_POL_OFS, 32'h0);
		chk(rd, 32'h00000fff);
		settle();
		chk({psen.oe_n, pwm.oe_n, flt.oe_n}, 23'h7fffff);
	endtask : t_float

	task automatic t_recall();
		@(posedge core_clk_in);
		recall <= 1'b1;
		repeat (2) settle();
		chk(flt.oe_n, 3'h0);
		repeat (6) settle();
		chk(line, 3'h0);
		@(posedge core_clk_in);
		mon <= 1'b1;
		#1;
		chk(flt.oe_n, 3'h7);
	endtask : t_recall

	task automatic t_psen();
		wr(`SEM_PSEN_POL_OFS, 32'h3c3);
		wr(`SEM_PSEN_OD_OFS, 32'h0ff);
		wr(`SEM_PSEN_DRIVE_OFS, 32'hfff);
		settle();
		chk(psen.val, 12'h300);
		chk(psen.oe_n, 12'h0c3);
	endtask : t_psen

	task automatic t_pwm();
		int hi;
		int bad_full;
		int bad_zero;
		hi = 0;
		bad_full = 0;
		bad_zero = 0;
		settle();
		chk(pwm.oe_n, 8'hff);
		wr(`SEM_PWM_EN_OFS, 32'h07);
		wr(`SEM_PWM_DUTY0_OFS, 32'hff);
		wr(`SEM_PWM_DUTY0_OFS + 12'h004, 32'h00);
		wr(`SEM_PWM_DUTY0_OFS + 12'h008, 32'h80);
		wr(`SEM_PWM_GPO_OFS, 32'h80);
		wr(`SEM_PWM_GVAL_OFS, 32'h80);
		settle();
		chk(pwm.oe_n, 8'h78);
		chk(pwm.val[7], 1'b1);
		// one whole period of 255 steps of 20 clocks
		repeat (5100) begin
			settle();
			if (pwm.val[2] === 1'b1) hi++;
			if (pwm.val[0] !== 1'b1) bad_full++;
			if (pwm.val[1] !== 1'b0) bad_zero++;
		end
		chk(bad_full, 0);
		chk(bad_zero, 0);
		chk(hi, 2560);
	endtask : t_pwm

	task automatic t_fault();
		wr(`SEM_PSEN_POL_OFS, 32'hfff);
		wr(`SEM_PSEN_OD_OFS, 32'h0);
		wr(`SEM_PSEN_GPO_OFS, 32'h020);
		wr(`SEM_PSEN_DRIVE_OFS, 32'h0e0);
		wr(`SEM_FLT_ASSERT0_OFS + 12'h004, 32'h004);
		wr(`SEM_FLT_SHDN0_OFS, 32'h080);
		wr(`SEM_FLT_SHDN0_OFS + 12'h004, 32'h060);
		@(posedge core_clk_in);
		cfault <= 12'h004;
		#1;
		chk(flt.oe_n, 3'h5);
		repeat (4) settle();
		chk(shdn, 12'h060);
		chk(psen.val, 12'h0a0);
		chk(irq, 1'b0);
		@(posedge core_clk_in);
		cfault <= 12'h000;
		peer <= 3'h1;
		repeat (4) settle();
		chk(shdn, 12'h080);
		chk(flt.oe_n, 3'h7);
		apb(1'b0, `SEM_IRQ_STATUS_OFS, 32'h0);
		chk(rd, 32'h0000000b);
		wr(`SEM_IRQ_MASK_OFS, 32'h1);
		settle();
		chk(irq, 1'b1);
		@(posedge core_clk_in);
		peer <= 3'h0;
		wr(`SEM_IRQ_STATUS_OFS, 32'hb);
		settle();
		chk(irq, 1'b0);
		apb(1'b0, 12'h100, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h00000000);
	endtask : t_fault

	task automatic t_rst();
		wr(`SEM_FLT_ASSERT0_OFS, 32'h001);
		@(posedge core_clk_in);
		cfault <= 12'h001;
		#1;
		chk(flt.oe_n, 3'h6);
		@(posedge core_clk_in);
		rstn_in <= 1'b0;
		#1;
		chk(flt.oe_n, 3'h7);
		chk({psen.oe_n, pwm.oe_n, shdn}, 32'hfffff000);
		@(posedge core_clk_in);
		recall <= 1'b0;
		@(posedge core_clk_in);
		rstn_in <= 1'b1;
		repeat (2) settle();
		chk({psen.oe_n, pwm.oe_n, flt.oe_n}, 23'h7fffff);
	endtask : t_rst

	initial begin
		t_float();
		t_recall();
		t_psen();
		t_pwm();
		t_fault();
		t_rst();
		results();
	end
endmodule : sem_supply_pins_bench

`default_nettype wire
